// File: design/jtag_prom_pkg.sv
package jtag_prom_pkg;

    // ==========================================================
    // Instruction register
    localparam int           IR_WIDTH      = 8;
    localparam logic [7:0]   OP_EXTEST     = 8'h00;
    localparam logic [7:0]   OP_SAMPLE     = 8'h01;
    localparam logic [7:0]   OP_CLAMP      = 8'hFA;
    localparam logic [7:0]   OP_HIGHZ      = 8'hFC;
    localparam logic [7:0]   OP_USERCODE   = 8'hFD;
    localparam logic [7:0]   OP_IDCODE     = 8'hFE;
    localparam logic [7:0]   OP_BYPASS     = 8'hFF;
    localparam logic [7:0]   OP_RELOAD     = 8'hEE;
    localparam logic [7:0]   OP_SEC_SET    = 8'hE0;
    localparam logic [7:0]   OP_ERASE_ALL  = 8'hE1;
    localparam logic [7:0]   OP_READ_DATA  = 8'hE2;
    localparam logic [7:0]   OP_ISP_ENTER  = 8'hE8;
    localparam logic [7:0]   OP_ISP_EXIT   = 8'hE9;

    // ==========================================================
    // Capture pattern fields
    localparam logic [2:0]   CAP_HIGH      = 3'h0;
    localparam logic         CAP_BIT2      = 1'b0;
    localparam logic [1:0]   CAP_LOW       = 2'h1;
    localparam int           CAP_ISP_POS   = 4;
    localparam int           CAP_SEC_POS   = 3;

    // ==========================================================
    // Data registers
    localparam int           DR_WIDTH      = 32;
    localparam logic [31:0]  ID_VALUE      = 32'h0ABC_DEF1;  // Arbitrary identity
    localparam logic [31:0]  USER_BLANK    = 32'hFFFF_FFFF;

    // ==========================================================
    // Reload pulse timing
    localparam int           CLK_MHZ       = 20;
    localparam int           RELOAD_MIN_NS = 300;
    localparam int           RELOAD_MAX_NS = 500;
    localparam int           RELOAD_CYC    = (RELOAD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int           RELOAD_MAXCYC = (RELOAD_MAX_NS * CLK_MHZ) / 1000;
    localparam int           SYNC_STAGES   = 2;

endpackage

// File: design/bit_sync.sv
`timescale 1ns/1ps
module bit_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Data
    input  wire logic din,
    output logic      dout
);
    logic stage1Ff;
    logic stage2Ff;
    logic nxt_stage1;
    logic nxt_stage2;

    always_comb begin
        nxt_stage1 = din;
        nxt_stage2 = stage1Ff;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1Ff <= 1'b0;
            stage2Ff <= 1'b0;
        end else begin
            stage1Ff <= nxt_stage1;
            stage2Ff <= nxt_stage2;
        end
    end

    assign dout = stage2Ff;
endmodule // bit_sync

// File: design/reload_pulser.sv
`timescale 1ns/1ps
module reload_pulser #(
    parameter int CYCLES = jtag_prom_pkg::RELOAD_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Trigger toggle from test clock domain
    input  wire logic trigToggle,
    // Open-drain style output, active low
    output logic      reloadPulse_n
);
    logic       trigSync;
    logic       lastFf;
    logic       nxt_last;
    logic [4:0] cntFf;
    logic [4:0] nxt_cnt;
    logic       outFf;
    logic       nxt_out;

    bit_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (trigToggle),
        .dout    (trigSync)
    );

    always_comb begin
        nxt_last = trigSync;
        nxt_cnt  = cntFf;
        if (trigSync != lastFf) begin
            nxt_cnt = 5'(CYCLES);
        end else if (cntFf != 5'h00) begin
            nxt_cnt = cntFf - 5'h01;
        end
        nxt_out = (nxt_cnt == 5'h00);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastFf <= 1'b0;
            cntFf  <= 5'h00;
            outFf  <= 1'b1;
        end else begin
            lastFf <= nxt_last;
            cntFf  <= nxt_cnt;
            outFf  <= nxt_out;
        end
    end

    assign reloadPulse_n = outFf;
endmodule // reload_pulser

// File: design/prom_jtag_tap.sv
// What this block does
// - Eight-bit instruction register between TDI, TDO
// - Capture loads fixed pattern 000x_x001
// - Captured value shifts out LSB first
// - Bit 4 shows programming mode
// - Bit 3 shows read security set
// - Decode BYPASS, SAMPLE, EXTEST codes
// - Decode CLAMP, IDCODE, USERCODE; 32-bit reads
// - HIGHZ floats all outputs together
// - Reload instruction pulses reload line low
// - Security blocks read, allows program, erase
// - Only full erase or system reset clears security bit
// - Programming mode keeps outputs high-Z/clamped
// - Programming done through JTAG instruction sequence
// - Reload pulse lasts 300 to 500 ns
// - Identity register 32 bits, LSB one
// - Blank user code reads all ones
`timescale 1ns/1ps
module prom_jtag_tap (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Test access port (link clock domain)
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdoOe_n,
    // Stored pattern and user code from the memory array
    input  wire logic        memBit,
    input  wire logic [31:0] userCode,
    input  wire logic        userCodeValid,
    // Outputs to device pins
    output logic             reloadPulse_n,
    output logic             pinsFloat,
    output logic             pinsClamp,
    output logic             inSystemProgrammingMode,
    output logic             readSecure
);
    // ==========================================================
    // TAP state machine
    typedef enum logic [15:0] {
        ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002, ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008, ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
        ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080, ST_UP_DR  = 16'h0100,
        ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000, ST_EX2_IR = 16'h4000,
        ST_UP_IR  = 16'h8000
    } tap_e;

    tap_e        stateFf;
    tap_e        nxt_state;
    logic [7:0]  irShiftFf;
    logic [7:0]  nxt_irShift;
    logic [7:0]  irFf;
    logic [7:0]  nxt_ir;
    logic [31:0] drFf;
    logic [31:0] nxt_dr;
    logic        tdoFf;
    logic        nxt_tdo;
    logic        tdoOeFf;
    logic        nxt_tdoOe;
    logic        ispFf;
    logic        nxt_isp;
    logic        secFf;
    logic        nxt_sec;
    logic        reloadTglFf;
    logic        nxt_reloadTgl;
    logic        floatFf;
    logic        nxt_float;
    logic        clampFf;
    logic        nxt_clamp;
    logic        ispSync;
    logic        secSync;
    logic        floatSync;
    logic        clampSync;
    logic        pinsFloatFf;
    logic        pinsClampFf;
    logic        ispOutFf;
    logic        secOutFf;
    logic        bypassFf;
    logic        nxt_bypass;
    logic        drIsData;

    always_comb begin
        nxt_state = stateFf;
        case (stateFf)
            ST_RESET:  nxt_state = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   nxt_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_state = tms ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  nxt_state = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: nxt_state = tms ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  nxt_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: nxt_state = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_state = tms ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  nxt_state = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: nxt_state = tms ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  nxt_state = tms ? ST_SEL_DR : ST_IDLE;
            default:   nxt_state = ST_RESET;
        endcase
    end

    // ==========================================================
    // Instruction and data registers, test clock domain
    always_comb begin
        nxt_irShift   = irShiftFf;
        nxt_ir        = irFf;
        nxt_dr        = drFf;
        nxt_isp       = ispFf;
        nxt_sec       = secFf;
        nxt_reloadTgl = reloadTglFf;
        case (stateFf)
            ST_RESET: begin
                nxt_ir = jtag_prom_pkg::OP_IDCODE;
            end
            ST_CAP_IR: begin
                nxt_irShift = {jtag_prom_pkg::CAP_HIGH, ispFf, secFf,
                               jtag_prom_pkg::CAP_BIT2,
                               jtag_prom_pkg::CAP_LOW};
            end
            ST_SH_IR: begin
                nxt_irShift = {tdi, irShiftFf[7:1]};
            end
            ST_UP_IR: begin
                nxt_ir = irShiftFf;
                if (irShiftFf == jtag_prom_pkg::OP_RELOAD) begin
                    nxt_reloadTgl = ~reloadTglFf;
                end
            end
            ST_CAP_DR: begin
                if (irFf == jtag_prom_pkg::OP_IDCODE) begin
                    nxt_dr = jtag_prom_pkg::ID_VALUE;
                end else if (irFf == jtag_prom_pkg::OP_USERCODE) begin
                    nxt_dr = userCodeValid ? userCode
                                           : jtag_prom_pkg::USER_BLANK;
                end else if (irFf == jtag_prom_pkg::OP_READ_DATA) begin
                    nxt_dr = {31'h00000000, memBit & ~secFf};
                end else begin
                    nxt_dr = 32'h00000000;
                end
            end
            ST_SH_DR: begin
                nxt_dr = {tdi, drFf[31:1]};
            end
            ST_UP_DR: begin
                if (irFf == jtag_prom_pkg::OP_ISP_ENTER) begin
                    nxt_isp = 1'b1;
                end else if (irFf == jtag_prom_pkg::OP_ISP_EXIT) begin
                    nxt_isp = 1'b0;
                end else if (irFf == jtag_prom_pkg::OP_SEC_SET && ispFf) begin
                    nxt_sec = 1'b1;
                end else if (irFf == jtag_prom_pkg::OP_ERASE_ALL && ispFf) begin
                    nxt_sec = 1'b0;
                end
            end
            default: begin
            end
        endcase
    end

    // ==========================================================
    // Data register selection and one-stage bypass register
    always_comb begin
        drIsData = 1'b0;
        if (irFf == jtag_prom_pkg::OP_IDCODE) begin
            drIsData = 1'b1;
        end else if (irFf == jtag_prom_pkg::OP_USERCODE) begin
            drIsData = 1'b1;
        end else if (irFf == jtag_prom_pkg::OP_READ_DATA) begin
            drIsData = 1'b1;
        end
    end

    // Every code without a data register of its own lands here
    always_comb begin
        nxt_bypass = bypassFf;
        if (stateFf == ST_CAP_DR) begin
            nxt_bypass = 1'b0;
        end else if (stateFf == ST_SH_DR) begin
            nxt_bypass = tdi;
        end
    end

    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            bypassFf <= 1'b0;
        end else begin
            bypassFf <= nxt_bypass;
        end
    end

    // ==========================================================
    // Pin control decode and serial output
    always_comb begin
        nxt_float = 1'b0;
        nxt_clamp = 1'b0;
        // Decoded from next values so the pins follow the update edge itself
        if (nxt_ir == jtag_prom_pkg::OP_HIGHZ) begin
            nxt_float = 1'b1;
        end else if (nxt_ir == jtag_prom_pkg::OP_CLAMP) begin
            nxt_clamp = 1'b1;
        end else if (nxt_ir == jtag_prom_pkg::OP_EXTEST
                     || nxt_ir == jtag_prom_pkg::OP_SAMPLE
                     || nxt_ir == jtag_prom_pkg::OP_BYPASS) begin
            nxt_clamp = 1'b0;
        end
        if (nxt_isp && !nxt_clamp) begin
            nxt_float = 1'b1;
        end
        nxt_tdo   = tdoFf;
        nxt_tdoOe = 1'b1;
        if (stateFf == ST_SH_IR) begin
            nxt_tdo   = irShiftFf[0];
            nxt_tdoOe = 1'b0;
        end else if (stateFf == ST_SH_DR) begin
            nxt_tdoOe = 1'b0;
            if (drIsData) begin
                nxt_tdo = drFf[0];
            end else begin
                nxt_tdo = bypassFf;
            end
        end
    end

    always_ff @(posedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            stateFf     <= ST_RESET;
            irShiftFf   <= 8'h00;
            irFf        <= jtag_prom_pkg::OP_IDCODE;
            drFf        <= 32'h00000000;
            ispFf       <= 1'b0;
            secFf       <= 1'b0;
            reloadTglFf <= 1'b0;
            floatFf     <= 1'b0;
            clampFf     <= 1'b0;
        end else begin
            stateFf     <= nxt_state;
            irShiftFf   <= nxt_irShift;
            irFf        <= nxt_ir;
            drFf        <= nxt_dr;
            ispFf       <= nxt_isp;
            secFf       <= nxt_sec;
            reloadTglFf <= nxt_reloadTgl;
            floatFf     <= nxt_float;
            clampFf     <= nxt_clamp;
        end
    end

    // TDO changes on the falling test clock edge
    always_ff @(negedge tck or posedge sys_rst) begin
        if (sys_rst) begin
            tdoFf   <= 1'b0;
            tdoOeFf <= 1'b1;
        end else begin
            tdoFf   <= nxt_tdo;
            tdoOeFf <= nxt_tdoOe;
        end
    end

    assign tdo     = tdoFf;
    assign tdoOe_n = tdoOeFf;

    // ==========================================================
    // Crossing into the system clock domain
    bit_sync u_syncIsp   (.clk(clk), .sys_rst(sys_rst), .din(ispFf),   .dout(ispSync));
    bit_sync u_syncSec   (.clk(clk), .sys_rst(sys_rst), .din(secFf),   .dout(secSync));
    bit_sync u_syncFloat (.clk(clk), .sys_rst(sys_rst), .din(floatFf), .dout(floatSync));
    bit_sync u_syncClamp (.clk(clk), .sys_rst(sys_rst), .din(clampFf), .dout(clampSync));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinsFloatFf <= 1'b0;
            pinsClampFf <= 1'b0;
            ispOutFf    <= 1'b0;
            secOutFf    <= 1'b0;
        end else begin
            pinsFloatFf <= floatSync;
            pinsClampFf <= clampSync;
            ispOutFf    <= ispSync;
            secOutFf    <= secSync;
        end
    end

    assign pinsFloat               = pinsFloatFf;
    assign pinsClamp               = pinsClampFf;
    assign inSystemProgrammingMode = ispOutFf;
    assign readSecure              = secOutFf;

    reload_pulser u_reload (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .trigToggle    (reloadTglFf),
        .reloadPulse_n (reloadPulse_n)
    );
endmodule // prom_jtag_tap

// File: dv/prom_jtag_chk.sv
`timescale 1ns/1ps
module prom_jtag_chk (
    // Clocks and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tck,
    // Watched signals
    input wire logic tms,
    input wire logic tdoOe_n,
    input wire logic reloadPulse_n,
    input wire logic pinsFloat,
    input wire logic pinsClamp,
    input wire logic inSystemProgrammingMode,
    input wire logic readSecure
);
    // ==========================================================
    // System clock domain
    property p_reloadWidth;
        @(posedge clk) disable iff (sys_rst)
        $fell(reloadPulse_n) |-> !reloadPulse_n [*6] ##1 reloadPulse_n;
    endproperty
    a_reloadWidth: assert property (p_reloadWidth) else $error("reload width wrong");
    property p_reloadGap;
        @(posedge clk) disable iff (sys_rst) $rose(reloadPulse_n) |-> reloadPulse_n [*8];
    endproperty
    a_reloadGap: assert property (p_reloadGap) else $error("reload pulse repeats");
    property p_floatClamp;
        @(posedge clk) disable iff (sys_rst) !(pinsFloat && pinsClamp);
    endproperty
    a_floatClamp: assert property (p_floatClamp) else $error("float and clamp both on");
    property p_ispFloat;
        @(posedge clk) disable iff (sys_rst)
        $rose(inSystemProgrammingMode) |-> ##[0:4] (pinsFloat || pinsClamp);
    endproperty
    a_ispFloat: assert property (p_ispFloat) else $error("outputs live in programming");
    property p_secStable;
        @(posedge clk) disable iff (sys_rst)
        readSecure && !inSystemProgrammingMode |=> readSecure;
    endproperty
    a_secStable: assert property (p_secStable) else $error("security cleared");
    property p_secRise;
        @(posedge clk) disable iff (sys_rst) $rose(readSecure) |-> inSystemProgrammingMode;
    endproperty
    a_secRise: assert property (p_secRise) else $error("security set outside mode");
    // ==========================================================
    // Test clock domain
    property p_shiftOe;
        @(posedge tck) disable iff (sys_rst) !tdoOe_n |-> !$past(tms);
    endproperty
    a_shiftOe: assert property (p_shiftOe) else $error("tdo driven outside shift");
    property p_tlrOe;
        @(posedge tck) disable iff (sys_rst) tms [*5] |=> tdoOe_n;
    endproperty
    a_tlrOe: assert property (p_tlrOe) else $error("tdo driven after test reset");
    c_reload: cover property (@(posedge clk) $fell(reloadPulse_n));
    c_isp: cover property (@(posedge clk) $rose(inSystemProgrammingMode));
    c_secure: cover property (@(posedge clk) $rose(readSecure));
endmodule  // prom_jtag_chk

// File: dv/jtag_ctrl_model.sv
`timescale 1ns/1ps
module jtag_ctrl_model (
    // Test access port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdoOe_n,
    // Programming reset request
    output logic      progRst
);
    logic tdoLine;
    // Released line reads the pull-up level
    assign tdoLine = tdoOe_n ? 1'b1 : tdo;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        progRst = 1'b0;
    end
    // One period; the clock rests low between frames
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #20;
        o = tdoLine;
        tck = 1'b1;
        #40;
        tck = 1'b0;
        #20;
    endtask
    task automatic goTlr();
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
    task automatic pulseReset();
        logic o;
        progRst = 1'b1;
        tick(1'b1, 1'b1, o);
        progRst = 1'b0;
    endtask
    // Full scan from idle, back to idle
    task automatic scan(input logic isIr, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        tick(1'b0, 1'b1, o);
        tick(1'b1, 1'b1, o);
        if (isIr)
            tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask
endmodule  // jtag_ctrl_model

// File: dv/prom_jtag_instruction_security_tb_top.sv
`timescale 1ns/1ps
module prom_jtag_instruction_security_tb_top;
    logic        clk, rstBench, sysRst, tck, tms, tdi, tdo, tdoOe_n, progRst;
    logic        memBit, userCodeValid, reloadPulse_n, pinsFloat, pinsClamp, in_system_programming_mode, readSecure;
    logic [31:0] userCode;
    int          mismatches, numChecks, cycles, lowCnt, lastLow;
    localparam logic [31:0] DR_IN = 32'h1234_5678;
    assign sysRst = rstBench | progRst;
    prom_jtag_tap uut (.clk(clk), .sys_rst(sysRst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe_n(tdoOe_n), .memBit(memBit), .userCode(userCode), .userCodeValid(userCodeValid),
        .reloadPulse_n(reloadPulse_n), .pinsFloat(pinsFloat), .pinsClamp(pinsClamp),
        .inSystemProgrammingMode(in_system_programming_mode), .readSecure(readSecure));
    jtag_ctrl_model jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n),
        .progRst(progRst));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (reloadPulse_n === 1'b0)
            lowCnt <= lowCnt + 1;
        else if (lowCnt != 0) begin
            lastLow <= lowCnt;
            lowCnt <= 0;
        end
        if (cycles == 20000) begin
            mismatches++;
            $display("CHECK FAILED timeout expected finish seen hang");
            giveVerdict();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] capPat(input logic ispOn, input logic secOn);
        return {jtag_prom_pkg::CAP_HIGH, ispOn, secOn, jtag_prom_pkg::CAP_BIT2,
                jtag_prom_pkg::CAP_LOW};
    endfunction
    task automatic ir(input logic [7:0] op, output logic [7:0] cap);
        logic [31:0] d;
        jtag.scan(1'b1, 8, {24'h0, op}, d);
        cap = d[7:0];
    endtask
    task automatic dr(output logic [31:0] d);
        jtag.scan(1'b0, 32, DR_IN, d);
        repeat (8) @(negedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic testReset();
        logic [7:0]  c;
        logic [31:0] d;
        dr(d);
        check("idcode after reset", jtag_prom_pkg::ID_VALUE, d);
        check("idcode lsb", 32'h1, 32'(d[0]));
        ir(jtag_prom_pkg::OP_BYPASS, c);
        check("capture idle", 32'(capPat(1'b0, 1'b0)), 32'(c));
        jtag.goTlr();
        dr(d);
        check("idcode after test reset", jtag_prom_pkg::ID_VALUE, d);
        $display("test reset done");
    endtask
    task automatic testCodes();
        logic [7:0]  c;
        logic [31:0] d, exp;
        logic [7:0]  ops [8];
        ops = '{jtag_prom_pkg::OP_EXTEST, jtag_prom_pkg::OP_SAMPLE, jtag_prom_pkg::OP_CLAMP,
                jtag_prom_pkg::OP_HIGHZ, jtag_prom_pkg::OP_USERCODE, jtag_prom_pkg::OP_IDCODE,
                jtag_prom_pkg::OP_BYPASS, 8'h5A};
        lastLow = 0;
        for (int i = 0; i < 8; i++) begin
            ir(ops[i], c);
            dr(d);
            check("float", 32'(ops[i] == jtag_prom_pkg::OP_HIGHZ), 32'(pinsFloat));
            check("clamp", 32'(ops[i] == jtag_prom_pkg::OP_CLAMP), 32'(pinsClamp));
            exp = (ops[i] == jtag_prom_pkg::OP_IDCODE) ? jtag_prom_pkg::ID_VALUE
                : (ops[i] == jtag_prom_pkg::OP_USERCODE) ? jtag_prom_pkg::USER_BLANK
                : {DR_IN[30:0], 1'b0};
            if (i > 1)
                check("data register", exp, d);
        end
        check("no reload", 32'h0, 32'(lastLow));
        @(negedge clk);
        userCode = 32'hC0DE_1234;
        userCodeValid = 1'b1;
        ir(jtag_prom_pkg::OP_USERCODE, c);
        dr(d);
        check("usercode", 32'hC0DE_1234, d);
        userCodeValid = 1'b0;
        dr(d);
        check("usercode blank", 32'hFFFF_FFFF, d);
        $display("test codes done");
    endtask
    task automatic testReload();
        logic [7:0] c;
        lastLow = 0;
        ir(jtag_prom_pkg::OP_RELOAD, c);
        repeat (20) @(negedge clk);
        check("reload cycles", 32'(jtag_prom_pkg::RELOAD_CYC), 32'(lastLow));
        check("reload ns", 32'h1, 32'(lastLow * 50 >= 300 && lastLow * 50 <= 500));
        $display("test reload done");
    endtask
    task automatic testIsp();
        logic [7:0]  c;
        logic [31:0] d;
        jtag.pulseReset();
        ir(jtag_prom_pkg::OP_ISP_ENTER, c);
        dr(d);
        check("program mode", 32'h1, 32'(in_system_programming_mode));
        check("float in mode", 32'h1, 32'(pinsFloat));
        ir(jtag_prom_pkg::OP_CLAMP, c);
        check("capture mode", 32'(capPat(1'b1, 1'b0)), 32'(c));
        dr(d);
        check("clamp in mode", 32'h1, 32'(pinsClamp & ~pinsFloat));
        @(negedge clk);
        memBit = 1'b1;
        ir(jtag_prom_pkg::OP_READ_DATA, c);
        dr(d);
        check("read open", 32'h1, 32'(d[0]));
        ir(jtag_prom_pkg::OP_SEC_SET, c);
        dr(d);
        check("secure set", 32'h1, 32'(readSecure));
        ir(jtag_prom_pkg::OP_READ_DATA, c);
        check("capture secure", 32'(capPat(1'b1, 1'b1)), 32'(c));
        dr(d);
        check("read blocked", 32'h0, 32'(d[0]));
        ir(jtag_prom_pkg::OP_ISP_EXIT, c);
        dr(d);
        ir(jtag_prom_pkg::OP_BYPASS, c);
        check("capture after exit", 32'(capPat(1'b0, 1'b1)), 32'(c));
        check("secure kept", 32'h1, 32'(readSecure));
        ir(jtag_prom_pkg::OP_ISP_ENTER, c);
        dr(d);
        ir(jtag_prom_pkg::OP_ERASE_ALL, c);
        dr(d);
        check("secure erased", 32'h0, 32'(readSecure));
        ir(jtag_prom_pkg::OP_ISP_EXIT, c);
        dr(d);
        ir(jtag_prom_pkg::OP_BYPASS, c);
        check("capture clear", 32'(capPat(1'b0, 1'b0)), 32'(c));
        $display("test programming done");
    endtask
    initial begin
        logic o;
        rstBench = 1'b1;
        memBit = 1'b0;
        userCode = 32'h0;
        userCodeValid = 1'b0;
        jtag.tick(1'b1, 1'b1, o);
        repeat (2) @(negedge clk);
        rstBench = 1'b0;
        testReset();
        testCodes();
        testReload();
        testIsp();
        giveVerdict();
    end
endmodule  // prom_jtag_instruction_security_tb_top

bind prom_jtag_tap prom_jtag_chk chk (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdoOe_n(tdoOe_n), .reloadPulse_n(reloadPulse_n), .pinsFloat(pinsFloat),
    .pinsClamp(pinsClamp), .inSystemProgrammingMode(inSystemProgrammingMode),
    .readSecure(readSecure));
